// ### core/hbt_pkg.sv
package hbt_pkg;

  // register byte offsets on the avalon slave
  localparam logic [3:0] HBT_OFS_BCR = 4'h0; // board_control_reg
  localparam logic [3:0] HBT_OFS_MODIFIER = 4'h4; // master_window_modifier_reg
  localparam logic [3:0] HBT_OFS_PAGE = 4'h8;
  localparam logic [3:0] HBT_OFS_BSR = 4'hc; // board_status_reg

  // board_control_reg fields
  localparam int HBT_BCR_DRQ = 0; // master_dma_request_enable
  localparam int HBT_BCR_DMA_DONE_IRQ_ENABLE = 1; // dma_done_irq_enable
  localparam int HBT_BCR_TOIE = 2; // timeout irq enable

  // master_window_modifier_reg fields
  localparam int HBT_MOD_AM_LSB = 0; // modifier code 4:0
  localparam int HBT_MOD_INDIV = 8; // indivisible_enable
  localparam int HBT_MOD_TCEND = 9; // dma_count_end_enable

  // board_status_reg fields (write 1 clears sticky bits)
  localparam int HBT_BSR_TO = 0; // remote_timeout_flag
  localparam int HBT_BSR_BERR = 1;
  localparam int HBT_BSR_PERR = 2;
  localparam int HBT_BSR_SEQ = 3; // block sequence open
  localparam int HBT_BSR_DONE = 4; // dma done seen

  // reset values
  localparam logic [15:0] HBT_RST_BCR = 16'h0000;
  localparam logic [15:0] HBT_RST_MOD = 16'h0000;
  localparam logic [15:0] HBT_RST_PAGE = 16'h0000;

  // host ready must finish within this, with margin taken off
  localparam int HBT_CLK_MHZ = 250;
  localparam int HBT_HOST_LIMIT_US = 15;
  localparam int HBT_MARGIN_US = 1;
  localparam int HBT_TIMEOUT_CYC = (HBT_HOST_LIMIT_US - HBT_MARGIN_US) * HBT_CLK_MHZ;

  // host access request carrier
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hbt_host_req_t;

  // expansion bus request carrier
  typedef struct packed {
    logic write;
    logic addr_phase;
    logic [4:0] modifier;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic lock;
  } hbt_exp_req_t;

endpackage : hbt_pkg

// ### core/hbt_timeout_counter.sv
`timescale 1ns/1ps
// counts cycles while a remote access is pending; fires once at the limit
module hbt_timeout_counter #(
  parameter int LIMIT = 3500
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  output logic expired
);
  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_q;

  initial begin
    if (LIMIT < 2) $error("hbt_timeout_counter: LIMIT too small");
  end

  // restart whenever no cycle is pending
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_q <= '0;
    end else if (cnt_q != W'(LIMIT)) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign expired = run && (cnt_q == W'(LIMIT - 1));
endmodule : hbt_timeout_counter

// ### core/hbt_sync3.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; a change counts when stages two and three agree
module hbt_sync3 (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin and result
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

  assign level = level_q;
endmodule : hbt_sync3

// ### core/hbt_bridge.sv
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - every host window access ends within 15 us, so the host never times out.
// - a remote access that waits too long is ended early as a backoff.
// - a backoff sets the timeout status flag and, if enabled, the interrupt.
// - block mode broadcasts address once with block modifier, then only data.
// - bus and parity errors during a block are latched for later reading.
// - indivisible on, dma off: each window host cycle is the next datum.
// - only the first address is broadcast; later window addresses just continue.
// - software clears indivisible before the last datum; block ends after it.
// - indivisible plus dma request enable moves block data by host dma.
// - after the first processor transfer, dma requests are raised per datum.
// - no other transfer during a dma block; status reads stay harmless.
// - dma-done interrupt enable raises interrupt when dma terminal count arrives.
// - count end enable clears indivisible at terminal count, ending the block.
// - dma reprogramming between rounds leaves the block sequence running.
// - indivisible sequences work as blocks, differing only in modifier code.
// - master cycles drive modifier register and page register on the bus.
// - block and indivisible sequences keep the expansion bus locked.
module hbt_bridge #(
  parameter int TIMEOUT_CYC = hbt_pkg::HBT_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // avalon-mm register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // host window access (host memory cycles into the master window)
  input wire logic host_req,
  input wire hbt_pkg::hbt_host_req_t host_cmd,
  input wire logic host_dack,
  input wire logic host_tc,
  output logic host_ready,
  output logic host_done,
  output logic host_backoff,
  output logic [15:0] host_rdata,
  output logic host_drq,
  output logic host_irq,
  // expansion bus master side
  output hbt_pkg::hbt_exp_req_t exp_req,
  output logic exp_valid,
  input wire logic exp_ack_pin,
  input wire logic exp_berr_pin,
  input wire logic exp_perr_pin,
  input wire logic [15:0] exp_rdata
);
  import hbt_pkg::*;

  typedef enum logic [3:0] {
    HBT_IDLE = 4'b0001,
    HBT_ISSUE = 4'b0010,
    HBT_WAIT = 4'b0100,
    HBT_END = 4'b1000
  } hbt_state_t;

  initial begin
    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 3750) $error("hbt_bridge: TIMEOUT_CYC out of range");
  end

  hbt_state_t state_q;
  logic [15:0] bcr_q;
  logic [15:0] mod_q;
  logic [15:0] page_q;
  logic to_flag_q;
  logic berr_q;
  logic perr_q;
  logic done_flag_q;
  logic seq_open_q;
  logic first_done_q;
  logic [31:0] avs_readdata_q;
  logic avs_wait_q;
  logic host_ready_q;
  logic host_done_q;
  logic host_backoff_q;
  logic [15:0] host_rdata_q;
  logic host_drq_q;
  logic host_irq_q;
  hbt_exp_req_t exp_req_q;
  logic exp_valid_q;
  hbt_host_req_t cmd_q;
  logic ack_s;
  logic berr_s;
  logic perr_s;
  logic ack_seen_q;
  logic expired;
  logic set_to;
  logic set_done;
  logic bsr_wr;
  logic mod_wr;
  logic tc_end;
  logic block_on;
  logic dma_mode;
  logic take;
  logic answered;
  logic cycle_end;

  // pin synchronisers for the remote handshake
  hbt_sync3 u_sync_ack (.clk(clk), .rst(rst), .pin(exp_ack_pin), .level(ack_s));
  hbt_sync3 u_sync_berr (.clk(clk), .rst(rst), .pin(exp_berr_pin), .level(berr_s));
  hbt_sync3 u_sync_perr (.clk(clk), .rst(rst), .pin(exp_perr_pin), .level(perr_s));

  // elapsed time from cycle start while a remote cycle pends
  hbt_timeout_counter #(.LIMIT(TIMEOUT_CYC)) u_timer (
    .clk(clk),
    .rst(rst),
    .run(state_q == HBT_WAIT),
    .expired(expired)
  );

  // status bit decode, used by the register read only
  function automatic logic [31:0] bsr_value(input logic to, input logic be, input logic pe,
                                            input logic seq, input logic dn);
    logic [31:0] v;
    v = '0;
    v[HBT_BSR_TO] = to;
    v[HBT_BSR_BERR] = be;
    v[HBT_BSR_PERR] = pe;
    v[HBT_BSR_SEQ] = seq;
    v[HBT_BSR_DONE] = dn;
    return v;
  endfunction : bsr_value

  assign block_on = mod_q[HBT_MOD_INDIV];
  assign dma_mode = block_on && bcr_q[HBT_BCR_DRQ];
  assign bsr_wr = avs_write && !avs_wait_q && (avs_address == HBT_OFS_BSR);
  assign mod_wr = avs_write && !avs_wait_q && (avs_address == HBT_OFS_MODIFIER);
  assign take = (state_q == HBT_IDLE) && host_req;
  assign answered = ack_s || berr_s;
  assign cycle_end = (state_q == HBT_END) && !ack_s;
  // an answer in the same cycle as the limit wins, so no false backoff
  assign set_to = (state_q == HBT_WAIT) && expired && !answered;
  assign set_done = host_tc && host_dack && seq_open_q;
  assign tc_end = set_done && mod_q[HBT_MOD_TCEND];

  // avalon: one wait cycle, then answer; reads are side-effect free
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_wait_q <= 1'b1;
      avs_readdata_q <= '0;
    end else begin
      if ((avs_read || avs_write) && avs_wait_q) begin
        avs_wait_q <= 1'b0;
        case (avs_address)
          HBT_OFS_BCR: avs_readdata_q <= {16'h0000, bcr_q};
          HBT_OFS_MODIFIER: avs_readdata_q <= {16'h0000, mod_q};
          HBT_OFS_PAGE: avs_readdata_q <= {16'h0000, page_q};
          HBT_OFS_BSR: avs_readdata_q <= bsr_value(to_flag_q, berr_q, perr_q, seq_open_q, done_flag_q);
          default: avs_readdata_q <= 32'h0000_0000;
        endcase
      end else begin
        avs_wait_q <= 1'b1;
      end
    end
  end

  // control registers; terminal count clears indivisible enable over software
  always_ff @(posedge clk) begin
    if (rst) begin
      bcr_q <= HBT_RST_BCR;
      mod_q <= HBT_RST_MOD;
      page_q <= HBT_RST_PAGE;
    end else begin
      if (avs_write && !avs_wait_q && avs_address == HBT_OFS_BCR) begin
        bcr_q <= {13'h0000, avs_writedata[2:0]};
      end
      if (avs_write && !avs_wait_q && avs_address == HBT_OFS_PAGE) begin
        page_q <= avs_writedata[15:0];
      end
      if (tc_end) begin
        mod_q[HBT_MOD_INDIV] <= 1'b0;
        mod_q[HBT_MOD_TCEND] <= 1'b0;
      end else if (mod_wr) begin
        mod_q <= {6'h00, avs_writedata[9:8], 3'h0, avs_writedata[4:0]};
      end
    end
  end

  // sticky status: set wins over a write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      to_flag_q <= 1'b0;
      berr_q <= 1'b0;
      perr_q <= 1'b0;
      done_flag_q <= 1'b0;
    end else begin
      to_flag_q <= set_to || (to_flag_q && !(bsr_wr && avs_writedata[HBT_BSR_TO]));
      berr_q <= (berr_s && state_q == HBT_WAIT) ||
                (berr_q && !(bsr_wr && avs_writedata[HBT_BSR_BERR]));
      perr_q <= (perr_s && state_q == HBT_WAIT) ||
                (perr_q && !(bsr_wr && avs_writedata[HBT_BSR_PERR]));
      done_flag_q <= set_done || (done_flag_q && !(bsr_wr && avs_writedata[HBT_BSR_DONE]));
    end
  end

  // interrupt follows enabled sticky events
  always_ff @(posedge clk) begin
    if (rst) begin
      host_irq_q <= 1'b0;
    end else begin
      host_irq_q <= (to_flag_q && bcr_q[HBT_BCR_TOIE]) ||
                    (done_flag_q && bcr_q[HBT_BCR_DMA_DONE_IRQ_ENABLE]);
    end
  end

  // remote cycle state: idle, issue, wait for answer or limit, wait for answer to drop
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= HBT_IDLE;
    end else begin
      case (state_q)
        HBT_IDLE: begin
          if (host_req) begin
            state_q <= HBT_ISSUE;
          end
        end
        HBT_ISSUE: begin
          state_q <= HBT_WAIT;
        end
        HBT_WAIT: begin
          if (answered || expired) begin
            state_q <= HBT_END;
          end
        end
        HBT_END: begin
          // the pin must drop before the next cycle, or its answer would be taken twice
          if (!ack_s) begin
            state_q <= HBT_IDLE;
          end
        end
        default: begin
          state_q <= HBT_IDLE;
        end
      endcase
    end
  end

  // command held for the whole remote cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= '0;
    end else if (take) begin
      cmd_q <= host_cmd;
    end
  end

  // host handshake: ready held off from take until the answer has gone
  always_ff @(posedge clk) begin
    if (rst) begin
      host_ready_q <= 1'b1;
      host_done_q <= 1'b0;
      host_backoff_q <= 1'b0;
      host_rdata_q <= '0;
    end else begin
      host_done_q <= cycle_end;
      host_backoff_q <= set_to;
      if (take) begin
        host_ready_q <= 1'b0;
      end else if (cycle_end) begin
        host_ready_q <= 1'b1;
      end
      if (state_q == HBT_WAIT && answered) begin
        host_rdata_q <= exp_rdata;
      end
    end
  end

  // remembers an answer, so a backoff leaves the sequence state alone
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_seen_q <= 1'b0;
    end else if (state_q == HBT_ISSUE) begin
      ack_seen_q <= 1'b0;
    end else if (state_q == HBT_WAIT && answered) begin
      ack_seen_q <= 1'b1;
    end
  end

  // sequence opens on the first answered datum, closes on the first answered datum after indivisible drops
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_open_q <= 1'b0;
      first_done_q <= 1'b0;
    end else if (cycle_end && ack_seen_q) begin
      seq_open_q <= block_on;
      first_done_q <= block_on;
    end
  end

  // expansion valid from issue until the answer or the limit
  always_ff @(posedge clk) begin
    if (rst) begin
      exp_valid_q <= 1'b0;
    end else if (state_q == HBT_ISSUE) begin
      exp_valid_q <= 1'b1;
    end else if (state_q == HBT_WAIT && (answered || expired)) begin
      exp_valid_q <= 1'b0;
    end
  end

  // request fields frozen while valid; lock spans the whole sequence, last datum included
  always_ff @(posedge clk) begin
    if (rst) begin
      exp_req_q <= '0;
    end else if (state_q == HBT_ISSUE) begin
      exp_req_q.write <= cmd_q.write;
      exp_req_q.wdata <= cmd_q.wdata;
      exp_req_q.modifier <= mod_q[HBT_MOD_AM_LSB +: 5];
      exp_req_q.addr <= {page_q, cmd_q.addr};
      // address only on the first datum of a sequence
      exp_req_q.addr_phase <= !seq_open_q;
      exp_req_q.lock <= block_on || seq_open_q;
    end else if (cycle_end) begin
      exp_req_q.lock <= block_on;
    end else if (state_q == HBT_IDLE && !block_on && !seq_open_q) begin
      exp_req_q.lock <= 1'b0;
    end
  end

  // dma request per remaining datum after the first processor transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      host_drq_q <= 1'b0;
    end else begin
      host_drq_q <= dma_mode && first_done_q && seq_open_q && state_q == HBT_IDLE &&
                    !host_req && !host_dack;
    end
  end

  assign avs_readdata = avs_readdata_q;
  assign avs_waitrequest = avs_wait_q;
  assign host_ready = host_ready_q;
  assign host_done = host_done_q;
  assign host_backoff = host_backoff_q;
  assign host_rdata = host_rdata_q;
  assign host_drq = host_drq_q;
  assign host_irq = host_irq_q;
  assign exp_req = exp_req_q;
  assign exp_valid = exp_valid_q;
endmodule : hbt_bridge

// ### verif/hbt_slave_model.sv
`timescale 1ns/1ps
// remote slave: answers after wait_cyc cycles, 8'hff never answers
module hbt_slave_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus side
  input wire hbt_pkg::hbt_exp_req_t req,
  input wire logic valid,
  output logic ack,
  output logic berr,
  output logic [15:0] rdata,
  // knobs
  input wire logic [7:0] wait_cyc,
  input wire logic give_berr
);
  import hbt_pkg::*;
  logic [7:0] cnt_q;
  // ack held until valid drops; data toggles while valid is low
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
      ack <= 1'h0;
      berr <= 1'h0;
      rdata <= 16'h0000;
    end else if (!valid) begin
      cnt_q <= 8'h00;
      ack <= 1'h0;
      berr <= 1'h0;
      rdata <= ~rdata;
    end else if (cnt_q == wait_cyc && wait_cyc != 8'hff) begin
      ack <= 1'h1;
      berr <= give_berr;
      rdata <= req.addr[15:0] ^ 16'h5a5a;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule : hbt_slave_model

// ### verif/hbt_bridge_assertions.sv
`timescale 1ns/1ps
// host window and expansion bus timing seen at the bridge ports
module hbt_bridge_assertions #(
  parameter int TIMEOUT_CYC = 3500
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // watched ports
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic host_ready,
  input wire logic host_done,
  input wire logic host_backoff,
  input wire hbt_pkg::hbt_exp_req_t exp_req,
  input wire logic exp_valid
);
  import hbt_pkg::*;
  // sync delay and end state margin on top of the limit
  localparam int TO_MAX = TIMEOUT_CYC + 16;
  int pend_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // counter, since the limit is too long for a delay range
  always_ff @(posedge clk) begin
    if (rst || host_ready)
      pend_q <= 0;
    else
      pend_q <= pend_q + 1;
  end
  host_limit_a: assert property (pend_q <= TO_MAX)
    else $error("host cycle overran limit");
  done_pulse_a: assert property (host_done |=> !host_done)
    else $error("done longer than one cycle");
  backoff_end_a: assert property (host_backoff |-> !host_ready ##[1:16] host_done)
    else $error("backoff not ended");
  early_backoff_a: assert property ($fell(host_ready) |-> (!host_backoff) [*8])
    else $error("backoff too early");
  pend_ready_a: assert property (exp_valid |-> !host_ready)
    else $error("ready during remote cycle");
  cycle_start_a: assert property ($fell(host_ready) |-> ##[0:3] exp_valid)
    else $error("window cycle not sent");
  seq_lock_a: assert property (exp_valid && !exp_req.addr_phase |-> exp_req.lock)
    else $error("data phase unlocked");
  req_stable_a: assert property (exp_valid && $past(exp_valid) |-> $stable(exp_req))
    else $error("bus request moved");
  avs_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access unanswered");
endmodule : hbt_bridge_assertions
bind hbt_bridge hbt_bridge_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.clk, .rst, .avs_read, .avs_write,
  .avs_waitrequest, .host_ready, .host_done, .host_backoff, .exp_req, .exp_valid);

// ### verif/hbt_bridge_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module hbt_bridge_tb;
  import hbt_pkg::*;
  localparam int TO = 20;
  localparam logic [4:0] BLK_AM = 5'h0b; // block code of our choosing
  localparam logic [4:0] IND_AM = 5'h09; // indivisible code of our choosing
  logic clk = 1'h0, rst = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic host_req = 1'h0, host_dack = 1'h0, host_tc = 1'h0;
  logic host_ready, host_done, host_backoff, host_drq, host_irq, exp_valid, ack, berr, v_last, b_last;
  hbt_host_req_t host_cmd = '0;
  hbt_exp_req_t exp_req, xe;
  logic [15:0] host_rdata, exp_rdata, he, a, d, lfsr = 16'h000c;
  logic [7:0] wait_cyc = 8'h03;
  logic give_berr = 1'h0;
  logic [63:0] ae, aq[$];
  logic [15:0] hq[$];
  hbt_exp_req_t xq[$];
  logic [4:0] m;
  int err_total = 0, tests_run = 0, i, k, n;
  always #2 clk = ~clk;
  hbt_bridge #(.TIMEOUT_CYC(TO)) u_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .host_req, .host_cmd, .host_dack, .host_tc, .host_ready, .host_done,
    .host_backoff, .host_rdata, .host_drq, .host_irq, .exp_req, .exp_valid, .exp_ack_pin(ack),
    .exp_berr_pin(berr), .exp_perr_pin(berr), .exp_rdata);
  hbt_slave_model u_slave (.clk, .rst, .req(exp_req), .valid(exp_valid), .ack, .berr, .rdata(exp_rdata),
    .wait_cyc, .give_berr);
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  task automatic finish_test;
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // avalon master: hold until waitrequest is sampled low
  task automatic avs(input logic w, input logic [3:0] ad, input logic [31:0] wd);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (!avs_waitrequest) break;
    end
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (n == 50) begin
      `CHK("avs_timeout", 1'h0, avs_waitrequest)
      finish_test();
    end
    @(posedge clk);
  endtask : avs
  task automatic rd(input logic [3:0] ad, input logic [31:0] mk, input logic [31:0] ev);
    aq.push_back({mk, ev});
    avs(1'h0, ad, 32'h0);
  endtask : rd
  // host window cycle; request drops in the cycle of done
  task automatic hc(input logic w, input logic dk, input logic tc);
    host_req <= 1'h1;
    host_cmd <= '{w, a, d};
    host_dack <= dk;
    host_tc <= tc;
    fork
      @(posedge host_done);
      repeat (TO + 60) @(posedge clk);
    join_any
    disable fork;
    host_req <= 1'h0;
    host_dack <= 1'h0;
    host_tc <= 1'h0;
    `CHK("host_done", 1'h1, host_done)
    if (host_done !== 1'h1) finish_test();
    @(posedge clk);
  endtask : hc
  // next datum; the caller's wait_cyc decides between answer and backoff
  task automatic burst(input logic ap, input logic lk, input logic w, input logic dk, input logic tc);
    lfsr = nxt(lfsr);
    a = lfsr;
    lfsr = nxt(lfsr);
    d = w ? lfsr : 16'h0;
    xq.push_back(hbt_exp_req_t'{w, ap, m, {16'h1234, a}, d, lk});
    hc(w, dk, tc);
  endtask : burst
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    `CHK("host_irq", e, host_irq)
    @(posedge clk);
  endtask : irq_is
  // oldest note against each result as it appears
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest && aq.size() > 0) begin
      ae = aq.pop_front();
      `CHK("avs_readdata", ae[31:0], avs_readdata & ae[63:32])
    end
    if (host_done && !host_cmd.write && hq.size() > 0) begin
      he = hq.pop_front();
      `CHK("host_rdata", he, host_rdata)
    end
    if (exp_valid && !v_last && xq.size() > 0) begin
      xe = xq.pop_front();
      `CHK("exp_ctl", {xe.write, xe.addr_phase, xe.modifier, xe.lock}, {exp_req.write, exp_req.addr_phase, exp_req.modifier, exp_req.lock})
      if (xe.addr_phase) `CHK("exp_addr", xe.addr, exp_req.addr)
      if (xe.write) `CHK("exp_wdata", xe.wdata, exp_req.wdata)
    end
    if (host_done) `CHK("host_backoff", wait_cyc == 8'hff, b_last)
    v_last = exp_valid;
    b_last = host_backoff;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    // reset values and an unmapped hole
    rd(HBT_OFS_BCR, 32'hffff, {16'h0, HBT_RST_BCR});
    rd(HBT_OFS_MODIFIER, 32'hffff, {16'h0, HBT_RST_MOD});
    rd(HBT_OFS_PAGE, 32'hffff, {16'h0, HBT_RST_PAGE});
    rd(HBT_OFS_BSR, 32'h1f, 32'h0);
    rd(4'h2, 32'hffffffff, 32'h0);
    // plain read through page and modifier
    m = 5'h11;
    avs(1'h1, HBT_OFS_PAGE, 32'h1234);
    avs(1'h1, HBT_OFS_MODIFIER, {27'h0, m});
    hq.push_back(nxt(lfsr) ^ 16'h5a5a);
    burst(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    // stuck slave: backoff, flag, interrupt, clear, retry
    avs(1'h1, HBT_OFS_BCR, 32'h1 << HBT_BCR_TOIE);
    wait_cyc <= 8'hff;
    burst(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    rd(HBT_OFS_BSR, 32'h1, 32'h1);
    irq_is(1'h1);
    wait_cyc <= 8'h03;
    avs(1'h1, HBT_OFS_BSR, 32'h1);
    irq_is(1'h0);
    hq.push_back(nxt(lfsr) ^ 16'h5a5a);
    burst(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    rd(HBT_OFS_BSR, 32'h1, 32'h0);
    // processor block then indivisible run, errors on every datum
    give_berr <= 1'h1;
    for (k = 0; k < 2; k++) begin
      m = k ? IND_AM : BLK_AM;
      avs(1'h1, HBT_OFS_MODIFIER, 32'h100 | m);
      for (i = 0; i < 4; i++) begin
        if (i == 3) avs(1'h1, HBT_OFS_MODIFIER, {27'h0, m});
        if (i == 1) rd(HBT_OFS_BSR, 32'h8, 32'h8);
        burst(i == 0, 1'h1, 1'h1, 1'h0, 1'h0);
      end
      rd(HBT_OFS_BSR, 32'he, 32'h6);
      avs(1'h1, HBT_OFS_BSR, 32'h6);
      rd(HBT_OFS_BSR, 32'h6, 32'h0);
    end
    // dma block ended by terminal count
    give_berr <= 1'h0;
    m = BLK_AM;
    avs(1'h1, HBT_OFS_BCR, (32'h1 << HBT_BCR_DRQ) | (32'h1 << HBT_BCR_DMA_DONE_IRQ_ENABLE));
    avs(1'h1, HBT_OFS_MODIFIER, 32'h300 | m);
    burst(1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    for (i = 1; i < 4; i++) begin
      for (k = 0; k < 100 && host_drq !== 1'h1; k++) @(posedge clk);
      `CHK("host_drq", 1'h1, host_drq)
      if (host_drq !== 1'h1) finish_test();
      burst(1'h0, 1'h1, 1'h1, 1'h1, i == 3);
    end
    rd(HBT_OFS_MODIFIER, 32'h300, 32'h0);
    rd(HBT_OFS_BSR, 32'h18, 32'h10);
    irq_is(1'h1);
    finish_test();
  end
endmodule : hbt_bridge_tb
